// ### logic/mcuex_core.sv
// execution core with its own data memory and stack
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1 - current-page table read: low to memory, high byte
// RL2 - last-page table read, two cycles, no flags
// RL3 - program counter low write adds one cycle
// RL4 - taken skip adds one cycle, else unchanged
// RL5 - watchdog clear zeroes counter, prescaler, both flags; an expiry in the same clock still sets the expired flag
// RL6 - pre-clear clears only after its partner ran
// RL7 - lone pre-clear leaves both flags unchanged
// RL8 - add with carry updates four flags
// RL9 - add of memory updates four flags
// RL10 - add immediate updates four flags
// RL11 - AND to accumulator updates zero only
// RL12 - AND to memory updates zero only
// RL13 - AND immediate updates zero only
// RL14 - call pushes next pc, jumps, no flags
// RL15 - byte clear writes zero, no flags
// RL16 - bit clear forces chosen bit low
// RL17 - nibble swap to memory or accumulator
// RL18 - immediate operands are eight bits
// RL19 - halt enters power-down in one cycle
// RL20 - halt stops clock, clears watchdog, sets flags
// RL21 - plain instructions advance pc by one
module mcuex_core (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          sys_rst,
    // instruction request
    input  wire logic                          instrValid,
    input  wire mcuex_pkg::mcuex_op_t          instrOp,
    input  wire logic [7:0]                    instrAddr,
    input  wire logic [7:0]                    instrImm,
    input  wire logic [2:0]                    instrBit,
    input  wire logic [mcuex_pkg::PC_W-1:0]    instrTarget,
    output logic                               instrReady,
    output logic                               instrDone,
    // program memory
    output logic [mcuex_pkg::PC_W-1:0]         progAddr,
    input  wire logic [mcuex_pkg::PROG_W-1:0]  progData,
    // wake pin and data memory peek
    input  wire logic                          wakeUp,
    input  wire logic [7:0]                    peekAddr,
    output logic [7:0]                         peekData,
    // state
    output logic [mcuex_pkg::PC_W-1:0]         pcOut,
    output logic [7:0]                         accumulator,
    output logic [mcuex_pkg::HIGH_W-1:0]       tableHighByte,
    output logic                               carryFlag,
    output logic                               zeroFlag,
    output logic                               halfCarryFlag,
    output logic                               signedResultWrapFlag,
    output logic                               watchdogExpiredFlag,
    output logic                               powerDownFlag,
    output logic [7:0]                         watchdogCount,
    output logic                               clockStopped
);
    logic [7:0]                       mem [mcuex_pkg::DATA_WORDS];
    logic [mcuex_pkg::PC_W-1:0]       stack [mcuex_pkg::STACK_DEPTH];
    mcuex_pkg::mcuex_state_t          state_r;
    mcuex_pkg::mcuex_op_t             op_r;
    logic [7:0]                       addr_r, imm_r, prescale_r, wdt_r, peek_r, acc_r;
    logic [2:0]                       bit_r, sp_r;
    logic [mcuex_pkg::PC_W-1:0]       target_r, pc_r, progAddr_r;
    logic [mcuex_pkg::CNT_W-1:0]      cnt_r;
    logic [mcuex_pkg::HIGH_W-1:0]     high_r;
    logic                             c_r, z_r, ac_r, ov_r, to_r, pd_r, halt_r;
    logic                             pre1_r, pre2_r, wake1_r, wake2_r;
    logic                             take, commit;
    logic [1:0]                       need;
    localparam int CNT_W = mcuex_pkg::CNT_W;

    // data memory read; the program counter low byte sits in the map
    function automatic logic [7:0] readByte(input logic [7:0] a);
        if (a == mcuex_pkg::PCL_ADDR)
            return pc_r[7:0];
        else if (a < 8'(mcuex_pkg::DATA_WORDS))
            return mem[a];
        return mcuex_pkg::BYTE_ZERO;
    endfunction

    function automatic logic writesMem(input mcuex_pkg::mcuex_op_t o);
        unique case (o)
            mcuex_pkg::OP_CLR_BYTE, mcuex_pkg::OP_SET_BYTE, mcuex_pkg::OP_CLR_BIT,
            mcuex_pkg::OP_SET_BIT, mcuex_pkg::OP_SWAP_MEM, mcuex_pkg::OP_ADC_MEM,
            mcuex_pkg::OP_ADD_MEM, mcuex_pkg::OP_AND_MEM, mcuex_pkg::OP_TAB_CUR,
            mcuex_pkg::OP_TAB_LAST: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sequencing: four clocks per instruction cycle

    assign instrReady = (state_r == mcuex_pkg::ST_IDLE) && !halt_r;
    assign take       = instrValid && instrReady;
    assign commit     = (state_r == mcuex_pkg::ST_EXEC) && (cnt_r == '0);
    assign instrDone  = commit;

    always_comb begin
        if (instrOp == mcuex_pkg::OP_CALL || instrOp == mcuex_pkg::OP_TAB_CUR ||
            instrOp == mcuex_pkg::OP_TAB_LAST)
            need = mcuex_pkg::CYC_TWO;                                     // see RL1
        else
            need = mcuex_pkg::CYC_ONE;
        if (writesMem(instrOp) && instrAddr == mcuex_pkg::PCL_ADDR)
            need = need + 2'h1;                                            // see RL3
        if (instrOp == mcuex_pkg::OP_SKIP_ZERO && readByte(instrAddr) == mcuex_pkg::BYTE_ZERO)
            need = need + 2'h1;                                            // see RL4
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= mcuex_pkg::ST_IDLE;
            cnt_r   <= '0;
        end else if (take) begin
            state_r <= mcuex_pkg::ST_EXEC;
            cnt_r   <= CNT_W'(need * 4'(mcuex_pkg::INSTR_CLOCKS) - 4'h1);
        end else if (commit) begin
            state_r <= mcuex_pkg::ST_IDLE;
        end else if (state_r == mcuex_pkg::ST_EXEC) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            op_r       <= mcuex_pkg::OP_NOP;
            addr_r     <= mcuex_pkg::BYTE_ZERO;
            imm_r      <= mcuex_pkg::BYTE_ZERO;
            bit_r      <= 3'h0;
            target_r   <= mcuex_pkg::PC_RESET;
            progAddr_r <= mcuex_pkg::PC_RESET;
        end else if (take) begin
            op_r     <= instrOp;
            addr_r   <= instrAddr;
            imm_r    <= instrImm;                                          // see RL18
            bit_r    <= instrBit;
            target_r <= instrTarget;
            // table pointer taken from the accumulator
            progAddr_r <= {(instrOp == mcuex_pkg::OP_TAB_LAST) ? mcuex_pkg::LAST_PAGE : pc_r[11:8],
                           acc_r};                                         // see RL2
        end
    end
    assign progAddr = progAddr_r;

    ////////////////////////////////////////////////////////////////////////
    // datapath, used on the commit clock

    logic [7:0] rd, wrVal, accN, addB;
    logic [8:0] sum;
    logic [4:0] half;
    logic       wrMem, cin, cN, zN, acN, ovN, skip, wdtClr;

    always_comb begin
        rd     = readByte(addr_r);
        wrMem  = 1'b0;
        wrVal  = rd;
        accN   = acc_r;
        cN     = c_r;
        zN     = z_r;
        acN    = ac_r;
        ovN    = ov_r;
        skip   = 1'b0;
        wdtClr = 1'b0;
        addB   = (op_r == mcuex_pkg::OP_ADD_IMM) ? imm_r : rd;
        cin    = (op_r == mcuex_pkg::OP_ADC_ACC || op_r == mcuex_pkg::OP_ADC_MEM) && c_r;
        sum    = {1'b0, acc_r} + {1'b0, addB} + {8'h00, cin};
        half   = {1'b0, acc_r[3:0]} + {1'b0, addB[3:0]} + {4'h0, cin};
        unique case (op_r)
            mcuex_pkg::OP_CLR_BYTE: begin
                wrMem = 1'b1;
                wrVal = mcuex_pkg::BYTE_ZERO;                              // see RL15
            end
            mcuex_pkg::OP_SET_BYTE: begin
                wrMem = 1'b1;
                wrVal = 8'hFF;
            end
            mcuex_pkg::OP_CLR_BIT: begin
                wrMem        = 1'b1;
                wrVal[bit_r] = 1'b0;                                       // see RL16
            end
            mcuex_pkg::OP_SET_BIT: begin
                wrMem        = 1'b1;
                wrVal[bit_r] = 1'b1;
            end
            mcuex_pkg::OP_SWAP_MEM: begin
                wrMem = 1'b1;
                wrVal = {rd[3:0], rd[7:4]};                                // see RL17
            end
            mcuex_pkg::OP_SWAP_ACC: accN = {rd[3:0], rd[7:4]};             // see RL17
            mcuex_pkg::OP_ADC_ACC, mcuex_pkg::OP_ADC_MEM, mcuex_pkg::OP_ADD_ACC,
            mcuex_pkg::OP_ADD_MEM, mcuex_pkg::OP_ADD_IMM: begin
                wrMem = (op_r == mcuex_pkg::OP_ADC_MEM || op_r == mcuex_pkg::OP_ADD_MEM);
                wrVal = sum[7:0];
                if (!wrMem)
                    accN = sum[7:0];
                cN  = sum[8];                                              // see RL8 RL9 RL10
                zN  = (sum[7:0] == mcuex_pkg::BYTE_ZERO);
                acN = half[4];
                ovN = (acc_r[7] == addB[7]) && (sum[7] != acc_r[7]);
            end
            mcuex_pkg::OP_AND_ACC, mcuex_pkg::OP_AND_MEM, mcuex_pkg::OP_AND_IMM: begin
                wrMem = (op_r == mcuex_pkg::OP_AND_MEM);                   // see RL12
                wrVal = acc_r & addB;
                if (!wrMem)
                    accN = acc_r & ((op_r == mcuex_pkg::OP_AND_IMM) ? imm_r : rd); // see RL11 RL13
                zN = ((acc_r & ((op_r == mcuex_pkg::OP_AND_IMM) ? imm_r : rd)) == mcuex_pkg::BYTE_ZERO);
            end
            mcuex_pkg::OP_TAB_CUR, mcuex_pkg::OP_TAB_LAST: begin
                wrMem = 1'b1;
                wrVal = progData[7:0];                                     // see RL1 RL2
            end
            mcuex_pkg::OP_SKIP_ZERO: skip = (rd == mcuex_pkg::BYTE_ZERO);
            mcuex_pkg::OP_WDT_CLR, mcuex_pkg::OP_HALT: wdtClr = 1'b1;      // see RL5 RL20
            mcuex_pkg::OP_WDT_PRE1: wdtClr = pre2_r;                       // see RL6
            mcuex_pkg::OP_WDT_PRE2: wdtClr = pre1_r;                       // see RL6
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // data memory and peek port

    always_ff @(posedge clock) begin
        if (commit && wrMem && addr_r != mcuex_pkg::PCL_ADDR && addr_r < 8'(mcuex_pkg::DATA_WORDS))
            mem[addr_r] <= wrVal;
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            peek_r <= mcuex_pkg::BYTE_ZERO;
        else
            peek_r <= readByte(peekAddr);
    end
    assign peekData = peek_r;

    ////////////////////////////////////////////////////////////////////////
    // program counter and stack; stack wraps

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pc_r <= mcuex_pkg::PC_RESET;
            sp_r <= 3'h0;
        end else if (commit) begin
            if (op_r == mcuex_pkg::OP_CALL) begin
                stack[sp_r] <= pc_r + 12'h001;                             // see RL14
                sp_r        <= (sp_r == 3'(mcuex_pkg::STACK_DEPTH - 1)) ? 3'h0 : sp_r + 3'h1;
                pc_r        <= target_r;
            end else if (wrMem && addr_r == mcuex_pkg::PCL_ADDR) begin
                pc_r <= {pc_r[11:8], wrVal};                               // see RL3
            end else if (skip) begin
                pc_r <= pc_r + 12'h002;                                    // see RL4
            end else begin
                pc_r <= pc_r + 12'h001;                                    // see RL21
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accumulator, arithmetic flags and table high byte

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc_r  <= mcuex_pkg::BYTE_ZERO;
            c_r    <= 1'b0;
            z_r    <= 1'b0;
            ac_r   <= 1'b0;
            ov_r   <= 1'b0;
            high_r <= '0;
        end else if (commit) begin
            acc_r <= accN;
            c_r   <= cN;
            z_r   <= zN;
            ac_r  <= acN;
            ov_r  <= ovN;
            if (op_r == mcuex_pkg::OP_TAB_CUR || op_r == mcuex_pkg::OP_TAB_LAST)
                high_r <= progData[mcuex_pkg::PROG_W-1:8];                 // see RL1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog, pre-clear pairing, halt and wake

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wake1_r <= 1'b0;
            wake2_r <= 1'b0;
        end else begin
            wake1_r <= wakeUp;
            wake2_r <= wake1_r;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prescale_r <= mcuex_pkg::WDT_RESET;
            wdt_r      <= mcuex_pkg::WDT_RESET;
            to_r       <= 1'b0;
            pd_r       <= 1'b0;
            pre1_r     <= 1'b0;
            pre2_r     <= 1'b0;
            halt_r     <= 1'b0;
        end else begin
            prescale_r <= prescale_r + 8'h01;
            if (prescale_r == 8'hFF)
                wdt_r <= wdt_r + 8'h01;
            if (commit && wdtClr) begin
                prescale_r <= mcuex_pkg::WDT_RESET;                        // see RL5 RL6
                wdt_r      <= mcuex_pkg::WDT_RESET;
                to_r       <= 1'b0;
                pd_r       <= (op_r == mcuex_pkg::OP_HALT);                // see RL19 RL20
                pre1_r     <= 1'b0;
                pre2_r     <= 1'b0;
            end else if (commit && op_r == mcuex_pkg::OP_WDT_PRE1) begin
                pre1_r <= 1'b1;                                            // see RL7
            end else if (commit && op_r == mcuex_pkg::OP_WDT_PRE2) begin
                pre2_r <= 1'b1;                                            // see RL7
            end
            // expiry wins over a clear, except a halt
            if (prescale_r == 8'hFF && wdt_r == 8'hFF && !(commit && op_r == mcuex_pkg::OP_HALT))
                to_r <= 1'b1;
            if (commit && op_r == mcuex_pkg::OP_HALT)
                halt_r <= 1'b1;                                            // see RL20
            else if (wake2_r)
                halt_r <= 1'b0;
        end
    end

    assign pcOut                = pc_r;
    assign accumulator          = acc_r;
    assign tableHighByte        = high_r;
    assign carryFlag            = c_r;
    assign zeroFlag             = z_r;
    assign halfCarryFlag        = ac_r;
    assign signedResultWrapFlag = ov_r;
    assign watchdogExpiredFlag  = to_r;
    assign powerDownFlag        = pd_r;
    assign watchdogCount        = wdt_r;
    assign clockStopped         = halt_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_single_timing: assert property (@(posedge clock) disable iff (sys_rst) // see RL21
        take && need == 2'h1 |-> !instrDone[*4] ##1 instrDone)
        else $error("one-cycle instruction late");
    a_double_timing: assert property (@(posedge clock) disable iff (sys_rst) // see RL1
        take && need == 2'h2 |-> ##8 instrDone)
        else $error("two-cycle instruction late");
    a_pcl_extra: assert property (@(posedge clock) disable iff (sys_rst) // see RL3
        take && instrOp == mcuex_pkg::OP_CLR_BYTE && instrAddr == mcuex_pkg::PCL_ADDR |-> ##8 instrDone)
        else $error("pc low write lacks extra cycle");
    a_wdt_clear: assert property (@(posedge clock) disable iff (sys_rst) // see RL5
        commit && op_r == mcuex_pkg::OP_WDT_CLR |=> !to_r && !pd_r && wdt_r == 8'h00)
        else $error("watchdog clear left state behind");
    a_lone_preclear: assert property (@(posedge clock) disable iff (sys_rst) // see RL7
        commit && op_r == mcuex_pkg::OP_WDT_PRE1 && !pre2_r |=> pd_r == $past(pd_r) && pre1_r)
        else $error("lone pre-clear changed power-down flag");
    a_and_carry: assert property (@(posedge clock) disable iff (sys_rst) // see RL11
        commit && op_r == mcuex_pkg::OP_AND_ACC |=> $stable(c_r) && $stable(ov_r) && $stable(ac_r))
        else $error("AND changed a flag other than zero");
    a_call_target: assert property (@(posedge clock) disable iff (sys_rst) // see RL14
        commit && op_r == mcuex_pkg::OP_CALL |=> pc_r == $past(target_r) && $stable(z_r))
        else $error("call did not load its target");
    a_halt_flags: assert property (@(posedge clock) disable iff (sys_rst) // see RL20
        commit && op_r == mcuex_pkg::OP_HALT |=> pd_r && !to_r && clockStopped && !instrReady)
        else $error("halt flags wrong");
    a_nop_pc: assert property (@(posedge clock) disable iff (sys_rst) // see RL21
        commit && op_r == mcuex_pkg::OP_NOP |=> pc_r == $past(pc_r) + 12'h001 && $stable(acc_r))
        else $error("no-operation did more than advance");
endmodule

`default_nettype wire

// ### pkg/mcuex_pkg.sv
// constants and types for the instruction execution subset
package mcuex_pkg;
    localparam int          PC_W         = 12;
    localparam int          PROG_W       = 15;
    localparam int          DATA_W       = 8;
    localparam int          HIGH_W       = PROG_W - DATA_W;
    localparam int          DATA_WORDS   = 160;
    localparam int          STACK_DEPTH  = 6;
    localparam int          INSTR_CLOCKS = 4;
    localparam int          CNT_W        = 4;
    localparam logic [7:0]  PCL_ADDR     = 8'h06;
    localparam logic [3:0]  LAST_PAGE    = 4'hF;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [11:0] PC_RESET     = 12'h000;
    localparam logic [7:0]  WDT_RESET    = 8'h00;
    localparam logic [1:0]  CYC_ONE      = 2'h1;
    localparam logic [1:0]  CYC_TWO      = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP       = 5'h00,
        OP_CLR_BYTE  = 5'h01,
        OP_SET_BYTE  = 5'h02,
        OP_CLR_BIT   = 5'h03,
        OP_SET_BIT   = 5'h04,
        OP_WDT_CLR   = 5'h05,
        OP_WDT_PRE1  = 5'h06,
        OP_WDT_PRE2  = 5'h07,
        OP_SWAP_MEM  = 5'h08,
        OP_SWAP_ACC  = 5'h09,
        OP_HALT      = 5'h0A,
        OP_ADC_ACC   = 5'h0B,
        OP_ADC_MEM   = 5'h0C,
        OP_ADD_ACC   = 5'h0D,
        OP_ADD_MEM   = 5'h0E,
        OP_ADD_IMM   = 5'h0F,
        OP_AND_ACC   = 5'h10,
        OP_AND_MEM   = 5'h11,
        OP_AND_IMM   = 5'h12,
        OP_CALL      = 5'h13,
        OP_TAB_CUR   = 5'h14,
        OP_TAB_LAST  = 5'h15,
        OP_SKIP_ZERO = 5'h16
    } mcuex_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } mcuex_state_t;
endpackage

// ### verification/mcuex_prog_model.sv
// program memory model with selectable latency
`timescale 1ns/1ps
`default_nettype none
module mcuex_prog_model (
    // clock and latency select
    input  wire logic        clock,
    input  wire logic        slow,
    // program memory port
    input  wire logic [11:0] progAddr,
    output logic [14:0]      progData
);
    logic [11:0] lastAddr_r = 12'h000;
    logic [2:0]  age_r      = 3'h0;
    logic [14:0] noise_r    = 15'h0000;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        lastAddr_r <= progAddr;
        noise_r <= noise_r + 15'h1357;
        if (progAddr != lastAddr_r)
            age_r <= 3'h1;
        else if (age_r != 3'h7)
            age_r <= age_r + 3'h1;
    end
    // noise until due, so early sampling fails
    assign progData = (progAddr == lastAddr_r && age_r >= (slow ? 3'h7 : 3'h1))
                    ? {progAddr[11:5] ^ 7'h2B, progAddr[7:0] ^ 8'hC3} : noise_r;
endmodule
`default_nettype wire

// ### verification/mcuex_core_tb.sv
// self-checking bench for the instruction execution core
`timescale 1ns/1ps
`default_nettype none
module mcuex_core_tb;
    typedef struct {
        int          take;
        int          n;
        logic [7:0]  m;
        logic [7:0]  acc;
        logic [3:0]  flg;
        logic [11:0] pc;
        bit          pcKnown;
        logic [7:0]  mem;
        logic [6:0]  th;
        logic [2:0]  pwr;
        bit          wz;
    } mcuex_note_t;
    logic                 clock, sys_rst, instrValid, instrReady, instrDone, wakeUp, slow, clockStopped;
    logic                 carryFlag, zeroFlag, halfCarryFlag, signedResultWrapFlag;
    logic                 watchdogExpiredFlag, powerDownFlag;
    mcuex_pkg::mcuex_op_t instrOp;
    logic [7:0]           instrAddr, instrImm, peekAddr, peekData, accumulator, watchdogCount;
    logic [2:0]           instrBit;
    logic [11:0]          instrTarget, progAddr, pcOut;
    logic [14:0]          progData;
    logic [6:0]           tableHighByte;
    int                   num_errors, n_checks, cyc;
    mcuex_note_t          q[$];
    // model: flg {wrap,zero,half,carry}, pwr {stop,down,expired}
    logic [7:0]           mem[256];
    logic [7:0]           acc;
    logic [3:0]           flg;
    logic [11:0]          pc;
    logic [6:0]           th;
    logic [2:0]           pwr;
    bit                   pcKnown, pre1, pre2;
    logic [4:0]           ops[18] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h09, 5'h0B, 5'h0C,
                                      5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h14, 5'h15, 5'h16};
    logic [7:0]           ms[4] = '{8'h20, 8'h21, 8'h9F, 8'hA0};
    ////////////////////////////////////////////////////////////////////////
    mcuex_core mcuex_core_inst (.clock, .sys_rst, .instrValid, .instrOp, .instrAddr, .instrImm, .instrBit,
        .instrTarget, .instrReady, .instrDone, .progAddr, .progData, .wakeUp, .peekAddr, .peekData, .pcOut,
        .accumulator, .tableHighByte, .carryFlag, .zeroFlag, .halfCarryFlag, .signedResultWrapFlag,
        .watchdogExpiredFlag, .powerDownFlag, .watchdogCount, .clockStopped);
    mcuex_prog_model mcuex_prog_model_inst (.clock, .slow, .progAddr, .progData);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // reference step, then hold until taken
    task automatic exec(input logic [4:0] op, input logic [7:0] m, input logic [7:0] x,
                        input logic [2:0] b = 3'h0, input logic [11:0] t = 12'h000);
        mcuex_note_t nt;
        logic [7:0]  d, e, r;
        logic [8:0]  s;
        logic [14:0] w;
        bit          wr, ci;
        int          k;
        d = (m < 8'hA0) ? mem[m] : 8'h00;
        e = (op == 5'h0F || op == 5'h12) ? x : d;
        r = d;
        wr = op inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h0C, 5'h0E, 5'h11, 5'h14, 5'h15};
        ci = op < 5'h0D && flg[0];
        nt.n = 1;
        nt.wz = 1'b0;
        case (op)
            5'h01: r = 8'h00;
            5'h02: r = 8'hFF;
            5'h03: r[b] = 1'b0;
            5'h04: r[b] = 1'b1;
            5'h08: r = {d[3:0], d[7:4]};
            5'h09: acc = {d[3:0], d[7:4]};
            5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F: begin
                s = {1'b0, acc} + e + ci;
                r = s[7:0];
                flg = {acc[7] == e[7] && r[7] != acc[7], r == 8'h00, acc[3:0] + e[3:0] + ci > 5'h0F, s[8]};
                acc = wr ? acc : r;
            end
            5'h10, 5'h11, 5'h12: begin
                r = acc & e;
                flg[2] = r == 8'h00;
                acc = wr ? acc : r;
            end
            5'h05: {pwr[1:0], nt.wz, pre1, pre2} = 5'b00100;
            5'h06, 5'h07: begin
                pre1 |= op == 5'h06;
                pre2 |= op == 5'h07;
                if (pre1 && pre2)
                    {pwr[1:0], nt.wz, pre1, pre2} = 5'b00100;
            end
            5'h0A: {pwr, nt.wz} = 4'b1101;
            5'h13: begin
                // common increment follows
                pc = t - 12'h001;
                nt.n = 2;
                pcKnown = 1'b1;
            end
            5'h14, 5'h15: begin
                w = {(op == 5'h14) ? pc[11:8] : 4'hF, acc};
                w = {w[11:5] ^ 7'h2B, w[7:0] ^ 8'hC3};
                r = w[7:0];
                th = w[14:8];
                nt.n = 2;
            end
            5'h16: if (d == 8'h00) begin
                nt.n = 2;
                pc = pc + 12'h001;
            end
            default: ;
        endcase
        pc = pc + 12'h001;
        if (wr && m == 8'h06) begin
            nt.n++;
            pcKnown = 1'b0;
        end else if (wr && m < 8'hA0)
            mem[m] = r;
        nt = '{0, nt.n, m, acc, flg, pc, pcKnown, (m < 8'hA0) ? mem[m] : 8'h00, th, pwr, nt.wz};
        instrOp = mcuex_pkg::mcuex_op_t'(op);
        {instrAddr, instrImm, instrBit, instrTarget} = {m, x, b, t};
        instrValid = 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (instrReady !== 1'b1 && k < 400);
        nt.take = cyc;
        q.push_back(nt);
        #1;
    endtask
    task automatic drain;
        int k;
        instrValid = 1'b0;
        wakeUp = 1'b0;
        for (k = 0; k < 400 && q.size() > 0; k++)
            @(posedge clock);
        repeat (3) @(posedge clock);
        #1;
    endtask
    // halt, refuse, wake, then one watchdog op
    task automatic halt_wake(input logic [4:0] op);
        exec(5'h0A, 8'h20, 8'h00);
        drain();
        pwr[2] = 1'b0;
        fork
            exec(op, 8'h20, 8'h00);
            begin
                repeat (10) @(posedge clock);
                chk(instrReady, 1'b0);
                #1 wakeUp = 1'b1;
            end
        join
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin : monitor
        mcuex_note_t nt;
        forever begin
            @(posedge clock);
            if (instrDone === 1'b1 && q.size() == 0)
                chk(32'h0, 32'h1);
            else if (instrDone === 1'b1) begin
                nt = q.pop_front();
                chk(cyc - nt.take, 4 * nt.n);
                #1 peekAddr = nt.m;
                @(posedge clock);
                chk(accumulator, nt.acc);
                chk({signedResultWrapFlag, zeroFlag, halfCarryFlag, carryFlag}, nt.flg);
                chk(tableHighByte, nt.th);
                chk({clockStopped, powerDownFlag, watchdogExpiredFlag}, nt.pwr);
                if (nt.wz)
                    chk(watchdogCount, 8'h00);
                if (nt.pcKnown)
                    chk(pcOut, nt.pc);
                @(posedge clock);
                if (nt.pcKnown)
                    chk(peekData, nt.mem);
            end
        end
    end
    initial begin
        {instrValid, wakeUp, slow, sys_rst} = 4'b0001;
        instrOp = mcuex_pkg::OP_NOP;
        {instrAddr, instrImm, instrBit, instrTarget, peekAddr} = 39'h0;
        {acc, flg, pc, th, pwr, pre1, pre2} = 36'h0;
        pcKnown = 1'b1;
        void'($urandom(32'h2A9E));
        repeat (8) @(posedge clock);
        #1 sys_rst = 1'b0;
        // working bytes; write above memory is dropped
        exec(5'h01, 8'h20, 8'h00);
        exec(5'h02, 8'h21, 8'h00);
        exec(5'h01, 8'h9F, 8'h00);
        exec(5'h02, 8'hA0, 8'h00);
        exec(5'h00, 8'h20, 8'h00);
        // flag boundaries
        exec(5'h12, 8'h20, 8'h00);
        exec(5'h0F, 8'h20, 8'h80);
        exec(5'h0F, 8'h20, 8'h80);
        exec(5'h0B, 8'h21, 8'h00);
        exec(5'h0F, 8'h20, 8'h0F);
        exec(5'h0F, 8'h20, 8'h01);
        for (int i = 0; i < 60; i++) begin
            slow = i >= 30;
            exec(ops[$urandom_range(17)], ms[$urandom_range(3)], 8'($urandom), 3'($urandom));
        end
        exec(5'h01, 8'h06, 8'h00);
        exec(5'h13, 8'h20, 8'h00, 3'h0, 12'hA5C);
        exec(5'h14, 8'h21, 8'h00);
        drain();
        halt_wake(5'h06);
        exec(5'h06, 8'h20, 8'h00);
        exec(5'h07, 8'h20, 8'h00);
        drain();
        halt_wake(5'h07);
        exec(5'h05, 8'h20, 8'h00);
        drain();
        chk(q.size(), 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
